/* include/prot_cmd_map.svh */
// Constants for the protection command sequencer
`ifndef PROT_CMD_MAP_SVH
`define PROT_CMD_MAP_SVH
`define CT_WRITE 3'h1
`define CT_READ 3'h5
`define ADDR_UNL1 12'h555
`define ADDR_UNL2 12'h2AA
`define ADDR_ERASE 12'h000
`define CMD_UNL1 8'hAA
`define CMD_UNL2 8'h55
`define CMD_PWD_ENT 8'h60
`define CMD_PPB_ENT 8'hC0
`define CMD_CFG_ENT 8'h40
`define CMD_PROG 8'hA0
`define CMD_EXIT 8'hF0
`define CMD_UL_START 8'h25
`define CMD_UL_CONF 8'h03
`define CMD_UL_DONE 8'h29
`define CMD_ERASE 8'h80
`define CMD_ERASE_CONF 8'h30
`define CMD_STATUS 8'h60
`define DATA_PPB_PROG 8'h00
`define PWD_WORD_LAST 2'h3
`define PWD_RST 16'hFFFF
`define STS_PPB_BIT 0
`define STS_LOCK_BIT 1
`endif

/* include/prot_cmd_pkg.sv */
// Types shared by the protection command sequencer
package prot_cmd_pkg;
	typedef struct packed {
		logic [2:0] kind;
		logic [44:0] addr;
		logic [15:0] data;
	} bus_cycle_t;

	typedef enum logic [3:0] {
		SET_NONE = 4'h1,
		SET_PWD = 4'h2,
		SET_PPB = 4'h4,
		SET_CFG = 4'h8
	} set_t;

	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_UNL1 = 10'h002,
		ST_UNL2 = 10'h004,
		ST_PROG = 10'h008,
		ST_ERASE = 10'h010,
		ST_UL1 = 10'h020,
		ST_ULW = 10'h040,
		ST_ULF = 10'h080,
		ST_STS = 10'h100,
		ST_SPARE = 10'h200
	} state_t;
endpackage : prot_cmd_pkg

/* design/sector_bit_mem.sv */
// Persistent protection bit per sector with registered read
`timescale 1ns/100ps
module sector_bit_mem #(
	parameter int DEPTH = 256,
	parameter int IDX_W = $clog2(DEPTH)
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic set_en_i,
	input wire logic [IDX_W-1:0] set_idx_i,
	input wire logic clr_all_i,
	input wire logic [IDX_W-1:0] rd_idx_i,
	output logic rd_bit_o
);
	logic [DEPTH-1:0] bits_q;

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_bit
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					bits_q[g] <= 1'b0;
				end else if (clr_all_i) begin
					bits_q[g] <= 1'b0;
				end else if (set_en_i && set_idx_i == IDX_W'(g)) begin
					bits_q[g] <= 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_bit_o <= 1'b0;
		end else begin
			rd_bit_o <= bits_q[rd_idx_i];
		end
	end
endmodule : sector_bit_mem

/* design/protection_command_sequencer.sv */
// Password and persistent sector protection command decoder
`timescale 1ns/100ps
`include "prot_cmd_map.svh"

// Functional notes
// [R1] Write cycles carry type 001b, read cycles 101b in the top bits.
// [R2] Unlock cycles compare only the low 12 address bits.
// [R3] AAh@555h, 55h@2AAh, 60h@555h enters the password command set.
// [R4] A0h then a data write stores the password word chosen by address 1:0.
// [R5] A read in the password set returns the word chosen by address 1:0.
// [R6] Unlock: 25h, 03h, four password words at words 0 to 3 in order, then 29h; 25h, 03h and 29h at word 0.
// [R7] F0h to any address leaves an entered command set.
// [R8] AAh@555h, 55h@2AAh, C0h@555h enters the persistent protection set.
// [R9] A0h then 00h at a sector address sets that sector's bit.
// [R10] 80h then 30h at low address 000h erases all persistent bits.
// [R11] A read in the persistent set returns that sector's bit.
// [R12] AAh@555h, 55h@2AAh, F0h inside a set returns to idle.
// [R13] 60h then a sector read returns that sector's status word.
// [R14] A read in the configuration set returns the configuration word.
// [R15] Commands outside their entered set are ignored; broken sequences go idle.
module protection_command_sequencer #(
	parameter int SECTORS = 256,
	parameter int SECT_LSB = 17
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic link_clk_i,
	input wire logic cyc_valid_i,
	input wire prot_cmd_pkg::bus_cycle_t cyc_i,
	output logic cmd_ready_o,
	output logic rd_valid_o,
	output logic [15:0] rd_data_o,
	input wire logic [15:0] cfg_word_i,
	output prot_cmd_pkg::set_t active_set_o,
	output logic pwd_unlocked_o
);
	localparam int SEC_W = $clog2(SECTORS);
	////////////////////////////////////////////////////////////////////////
	// Link side: hold one cycle until the core acknowledges it
	prot_cmd_pkg::bus_cycle_t hold_q;
	logic req_tog_q;
	logic hold_rd_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic ack_seen_q;
	logic ack_tog_q;
	logic [15:0] resp_q;

	// Only one cycle in flight, so hold_q and resp_q are stable when read
	assign cmd_ready_o = (req_tog_q == ack_seen_q);
	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_q <= '0;
			req_tog_q <= 1'b0;
			hold_rd_q <= 1'b0;
		end else if (cyc_valid_i && cmd_ready_o) begin
			hold_q <= cyc_i;
			req_tog_q <= ~req_tog_q;
			hold_rd_q <= (cyc_i.kind == `CT_READ); // [R1]
		end
	end

	always_ff @(posedge link_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_seen_q <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 16'h0000;
		end else begin
			ack_s1_q <= ack_tog_q;
			ack_s2_q <= ack_s1_q;
			ack_seen_q <= ack_s2_q;
			rd_valid_o <= (ack_s2_q != ack_seen_q) && hold_rd_q;
			if ((ack_s2_q != ack_seen_q) && hold_rd_q) begin
				rd_data_o <= resp_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core side: request crossing and two-step issue
	logic req_s1_q;
	logic req_s2_q;
	logic req_seen_q;
	logic go1_q;
	logic act;
	prot_cmd_pkg::bus_cycle_t cur_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_seen_q <= 1'b0;
			go1_q <= 1'b0;
			act <= 1'b0;
			cur_q <= '0;
		end else begin
			req_s1_q <= req_tog_q;
			req_s2_q <= req_s1_q;
			req_seen_q <= req_s2_q;
			go1_q <= (req_s2_q != req_seen_q);
			// Extra step lets the sector bit read settle on cur_q
			act <= go1_q;
			if (req_s2_q != req_seen_q) begin
				cur_q <= hold_q;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_tog_q <= 1'b0;
		end else if (act) begin
			ack_tog_q <= ~ack_tog_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decode helpers
	logic wr;
	logic rd;
	logic [7:0] cmd;
	logic a555;
	logic a2aa;
	logic a000;
	logic [1:0] wsel;
	logic [SEC_W-1:0] sect;
	assign wr = act && (cur_q.kind == `CT_WRITE); // [R1]
	assign rd = act && (cur_q.kind == `CT_READ); // [R1]
	assign cmd = cur_q.data[7:0];
	assign a555 = (cur_q.addr[11:0] == `ADDR_UNL1); // [R2]
	assign a2aa = (cur_q.addr[11:0] == `ADDR_UNL2); // [R2]
	assign a000 = (cur_q.addr[11:0] == `ADDR_ERASE); // [R2]
	assign wsel = cur_q.addr[1:0];
	assign sect = cur_q.addr[SECT_LSB +: SEC_W];

	////////////////////////////////////////////////////////////////////////
	// Command sequence state and entered command set
	prot_cmd_pkg::state_t state_q;
	prot_cmd_pkg::set_t set_q;
	logic [1:0] ul_cnt_q;
	assign active_set_o = set_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= prot_cmd_pkg::ST_IDLE;
			set_q <= prot_cmd_pkg::SET_NONE;
		end else if (rd) begin
			state_q <= prot_cmd_pkg::ST_IDLE;
		end else if (wr) begin
			state_q <= prot_cmd_pkg::ST_IDLE; // [R15]
			case (state_q)
				prot_cmd_pkg::ST_IDLE: begin
					if (cmd == `CMD_UNL1 && a555) begin
						state_q <= prot_cmd_pkg::ST_UNL1;
					end else if (set_q != prot_cmd_pkg::SET_NONE &&
						cmd == `CMD_EXIT) begin
						set_q <= prot_cmd_pkg::SET_NONE; // [R7]
					end else if (set_q == prot_cmd_pkg::SET_PWD) begin
						if (cmd == `CMD_PROG) begin
							state_q <= prot_cmd_pkg::ST_PROG; // [R4]
						end else if (cmd == `CMD_UL_START && wsel == 2'h0) begin
							state_q <= prot_cmd_pkg::ST_UL1; // [R6]
						end
					end else if (set_q == prot_cmd_pkg::SET_PPB) begin
						if (cmd == `CMD_PROG) begin
							state_q <= prot_cmd_pkg::ST_PROG; // [R9]
						end else if (cmd == `CMD_ERASE) begin
							state_q <= prot_cmd_pkg::ST_ERASE; // [R10]
						end else if (cmd == `CMD_STATUS) begin
							state_q <= prot_cmd_pkg::ST_STS; // [R13]
						end
					end
				end
				prot_cmd_pkg::ST_UNL1: begin
					if (cmd == `CMD_UNL2 && a2aa) begin
						state_q <= prot_cmd_pkg::ST_UNL2;
					end
				end
				prot_cmd_pkg::ST_UNL2: begin
					if (set_q != prot_cmd_pkg::SET_NONE) begin
						if (cmd == `CMD_EXIT) begin
							set_q <= prot_cmd_pkg::SET_NONE; // [R12]
						end
					end else if (a555 && cmd == `CMD_PWD_ENT) begin
						set_q <= prot_cmd_pkg::SET_PWD; // [R3]
					end else if (a555 && cmd == `CMD_PPB_ENT) begin
						set_q <= prot_cmd_pkg::SET_PPB; // [R8]
					end else if (a555 && cmd == `CMD_CFG_ENT) begin
						set_q <= prot_cmd_pkg::SET_CFG; // [R14]
					end
				end
				prot_cmd_pkg::ST_UL1: begin
					if (cmd == `CMD_UL_CONF && wsel == 2'h0) begin
						state_q <= prot_cmd_pkg::ST_ULW; // [R6]
					end
				end
				prot_cmd_pkg::ST_ULW: begin
					if (wsel == ul_cnt_q) begin
						state_q <= (ul_cnt_q == `PWD_WORD_LAST) ?
							prot_cmd_pkg::ST_ULF : prot_cmd_pkg::ST_ULW;
					end
				end
				default: begin
					state_q <= prot_cmd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Password words and unlock comparison
	logic [3:0][15:0] pwd_q;
	logic ul_match_q;
	logic pwd_we;
	assign pwd_we = wr && state_q == prot_cmd_pkg::ST_PROG &&
		set_q == prot_cmd_pkg::SET_PWD; // [R4]

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pwd_q <= {4{`PWD_RST}};
		end else if (pwd_we) begin
			pwd_q[wsel] <= cur_q.data; // [R4]
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ul_cnt_q <= 2'h0;
			ul_match_q <= 1'b0;
			pwd_unlocked_o <= 1'b0;
		end else if (wr) begin
			if (state_q == prot_cmd_pkg::ST_UL1) begin
				ul_cnt_q <= 2'h0;
				ul_match_q <= 1'b1;
			end else if (state_q == prot_cmd_pkg::ST_ULW) begin
				ul_cnt_q <= ul_cnt_q + 2'h1;
				ul_match_q <= ul_match_q && (cur_q.data == pwd_q[ul_cnt_q]);
			end else if (state_q == prot_cmd_pkg::ST_ULF &&
				cmd == `CMD_UL_DONE && wsel == 2'h0) begin
				// Wrong password leaves the lock as it was
				pwd_unlocked_o <= pwd_unlocked_o || ul_match_q; // [R6]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Persistent bits
	logic ppb_set;
	logic ppb_clr;
	logic ppb_bit;
	assign ppb_set = wr && state_q == prot_cmd_pkg::ST_PROG &&
		set_q == prot_cmd_pkg::SET_PPB && cmd == `DATA_PPB_PROG; // [R9]
	assign ppb_clr = wr && state_q == prot_cmd_pkg::ST_ERASE &&
		cmd == `CMD_ERASE_CONF && a000; // [R10]

	sector_bit_mem #(
		.DEPTH(SECTORS),
		.IDX_W(SEC_W)
	) u_bits (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.set_en_i(ppb_set),
		.set_idx_i(sect),
		.clr_all_i(ppb_clr),
		.rd_idx_i(sect),
		.rd_bit_o(ppb_bit)
	);

	////////////////////////////////////////////////////////////////////////
	// Read answers
	logic [15:0] sts_word;
	always_comb begin
		sts_word = 16'h0000;
		sts_word[`STS_PPB_BIT] = ppb_bit;
		sts_word[`STS_LOCK_BIT] = ~pwd_unlocked_o;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			resp_q <= 16'h0000;
		end else if (rd) begin
			if (state_q == prot_cmd_pkg::ST_STS) begin
				resp_q <= sts_word; // [R13]
			end else begin
				case (set_q)
					prot_cmd_pkg::SET_PWD: resp_q <= pwd_q[wsel]; // [R5]
					prot_cmd_pkg::SET_PPB: resp_q <= {15'h0000, ppb_bit}; // [R11]
					prot_cmd_pkg::SET_CFG: resp_q <= cfg_word_i; // [R14]
					default: resp_q <= 16'h0000; // [R15]
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	type_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R1]
		act && cur_q.kind != `CT_WRITE && cur_q.kind != `CT_READ |=>
		$stable(state_q) && $stable(set_q) && $stable(resp_q))
		else $error("unknown cycle type changed state");

	unlock_mask_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R2]
		wr && state_q == prot_cmd_pkg::ST_IDLE && cmd == `CMD_UNL1 &&
		cur_q.addr[11:0] == 12'h555 |=> state_q == prot_cmd_pkg::ST_UNL1)
		else $error("first unlock cycle not accepted");

	pwd_entry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R3]
		wr && state_q == prot_cmd_pkg::ST_UNL2 &&
		set_q == prot_cmd_pkg::SET_NONE && cmd == 8'h60 &&
		cur_q.addr[11:0] == 12'h555 |=> set_q == prot_cmd_pkg::SET_PWD)
		else $error("password set not entered");

	pwd_prog_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R4]
		pwd_we |=> pwd_q[$past(wsel)] == $past(cur_q.data))
		else $error("password word not stored");

	pwd_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R5]
		rd && set_q == prot_cmd_pkg::SET_PWD &&
		state_q != prot_cmd_pkg::ST_STS |=> resp_q == pwd_q[$past(wsel)])
		else $error("password read wrong word");

	unlock_done_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R6]
		wr && state_q == prot_cmd_pkg::ST_ULF && cmd == 8'h29 &&
		wsel == 2'h0 && ul_match_q |=> pwd_unlocked_o)
		else $error("matching password did not unlock");

	set_exit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R7]
		wr && state_q == prot_cmd_pkg::ST_IDLE && cmd == 8'hF0 |=>
		set_q == prot_cmd_pkg::SET_NONE)
		else $error("exit did not leave the set");

	ppb_entry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R8]
		wr && state_q == prot_cmd_pkg::ST_UNL2 &&
		set_q == prot_cmd_pkg::SET_NONE && cmd == 8'hC0 && a555 |=>
		set_q == prot_cmd_pkg::SET_PPB)
		else $error("persistent set not entered");

	ppb_prog_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R9]
		ppb_set |-> ##2 ppb_bit)
		else $error("sector bit not set");

	ppb_erase_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R10]
		ppb_clr |-> ##2 !ppb_bit)
		else $error("sector bits not erased");

	ppb_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R11]
		rd && set_q == prot_cmd_pkg::SET_PPB &&
		state_q == prot_cmd_pkg::ST_IDLE |=> resp_q == {15'h0000, $past(ppb_bit)})
		else $error("sector bit read wrong");

	set_reset_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R12]
		wr && state_q == prot_cmd_pkg::ST_UNL2 &&
		set_q != prot_cmd_pkg::SET_NONE && cmd == 8'hF0 |=>
		set_q == prot_cmd_pkg::SET_NONE && state_q == prot_cmd_pkg::ST_IDLE)
		else $error("reset sequence did not return to idle");

	status_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R13]
		rd && state_q == prot_cmd_pkg::ST_STS |=>
		resp_q[0] == $past(ppb_bit) && resp_q[1] == !$past(pwd_unlocked_o))
		else $error("status word wrong");

	cfg_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R14]
		rd && set_q == prot_cmd_pkg::SET_CFG &&
		state_q != prot_cmd_pkg::ST_STS |=> resp_q == $past(cfg_word_i))
		else $error("configuration word wrong");

	guard_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R15]
		wr && set_q == prot_cmd_pkg::SET_NONE &&
		state_q == prot_cmd_pkg::ST_IDLE && cmd == 8'hA0 |=>
		state_q == prot_cmd_pkg::ST_IDLE && !$past(pwd_we) && !$past(ppb_set))
		else $error("program accepted outside a set");

	unlock_cov: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(pwd_unlocked_o));
	erase_cov: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		ppb_clr);
	status_cov: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		rd && state_q == prot_cmd_pkg::ST_STS);
endmodule : protection_command_sequencer

/* test/host_model.sv */
// Host controller model driving the link bus of the sequencer
`timescale 1ns/100ps
module host_model (
	input wire logic link_clk_i,
	input wire logic ready_i,
	input wire logic rd_valid_i,
	input wire logic [15:0] rd_data_i,
	output logic valid_o,
	output prot_cmd_pkg::bus_cycle_t cyc_o,
	output logic hang_o
);
	initial begin
		valid_o = 1'b0;
		cyc_o = '0;
		hang_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One cycle in flight; offered only while ready is high
	task automatic xfer(input logic [2:0] kind, input logic [44:0] addr,
		input logic [15:0] data, output logic [15:0] rdata);
		int n;
		n = 0;
		rdata = 16'hXXXX;
		@(posedge link_clk_i);
		valid_o <= 1'b1;
		cyc_o <= {kind, addr, data};
		// Offer stands until an edge sees ready high
		do begin
			@(posedge link_clk_i);
			n++;
		end while (ready_i !== 1'b1 && n < 64);
		valid_o <= 1'b0;
		// Released bus flips so stale values never pass
		cyc_o <= ~{kind, addr, data};
		// Ready returns with the answer; take both at that edge
		do begin
			@(posedge link_clk_i);
			n++;
		end while (ready_i !== 1'b1 && n < 128);
		if (rd_valid_i === 1'b1) rdata = rd_data_i;
		if (n >= 128) hang_o = 1'b1;
	endtask : xfer
endmodule : host_model

/* test/protection_command_sequencer_test.sv */
// Self-checking bench for the protection command sequencer
`timescale 1ns/100ps
`include "prot_cmd_map.svh"
module protection_command_sequencer_test;
	logic clk_i = 1'b0;
	logic link_clk_i;
	logic rst_b_i = 1'b0;
	logic cyc_valid_i;
	prot_cmd_pkg::bus_cycle_t cyc_i;
	logic cmd_ready_o;
	logic rd_valid_o;
	logic [15:0] rd_data_o;
	logic [15:0] cfg_word_i = 16'h3C5A;
	prot_cmd_pkg::set_t active_set_o;
	logic pwd_unlocked_o;
	logic hang;
	int num_errors = 0;
	int samples_checked = 0;
	// High bits that unlock cycles must ignore
	localparam logic [44:0] HI = 45'h1ABCDE000000;
	localparam logic [44:0] SEC5 = 45'h0000000A0000;
	localparam logic [44:0] SEC6 = 45'h0000000C0000;

	always #50 clk_i = ~clk_i;
	initial begin
		link_clk_i = 1'b0;
		#33;
		forever #80 link_clk_i = ~link_clk_i;
	end

	protection_command_sequencer u_dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i),
		.cyc_valid_i(cyc_valid_i), .cyc_i(cyc_i),
		.cmd_ready_o(cmd_ready_o), .rd_valid_o(rd_valid_o),
		.rd_data_o(rd_data_o), .cfg_word_i(cfg_word_i),
		.active_set_o(active_set_o), .pwd_unlocked_o(pwd_unlocked_o)
	);
	host_model u_host (
		.link_clk_i(link_clk_i), .ready_i(cmd_ready_o),
		.rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
		.valid_o(cyc_valid_i), .cyc_o(cyc_i), .hang_o(hang)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [44:0] a, input logic [15:0] d);
		logic [15:0] r;
		u_host.xfer(`CT_WRITE, a, d, r);
	endtask : wr

	task automatic rd(input logic [44:0] a, input logic [15:0] e,
		input string nm);
		logic [15:0] r;
		u_host.xfer(`CT_READ, a, 16'h0000, r);
		chk(nm, e, r);
	endtask : rd

	task automatic chk_state(input logic [3:0] s, input logic u);
		// Core flags settle before the answer; a few core cycles of margin
		repeat (3) @(posedge clk_i);
		chk("active_set", {12'h000, s}, {12'h000, active_set_o});
		chk("unlocked", {15'h0000, u}, {15'h0000, pwd_unlocked_o});
	endtask : chk_state

	task automatic enter(input logic [15:0] c);
		wr(HI | 45'h555, 16'h00AA);
		wr(HI | 45'h2AA, 16'h0055);
		wr(HI | 45'h555, c);
	endtask : enter

	function automatic logic [15:0] pw(input int i);
		return 16'h1234 + 16'h1111 * i[15:0];
	endfunction : pw

	task automatic unlock(input logic [15:0] w3);
		wr(HI, 16'h0025);
		wr(HI, 16'h0003);
		for (int i = 0; i < 4; i++) wr(HI | i, (i == 3) ? w3 : pw(i));
		wr(HI, 16'h0029);
	endtask : unlock

	////////////////////////////////////////////////////////////////////////
	task automatic t_pwd;
		enter(16'h0060);
		chk_state(4'h2, 1'b0);
		rd(HI, 16'hFFFF, "pwd_reset");
		for (int i = 0; i < 4; i++) begin
			wr(HI, 16'h00A0);
			wr(HI | i, pw(i));
		end
		rd(HI | 45'h2, pw(2), "pwd_word2");
		rd(45'h1, pw(1), "pwd_word1");
		unlock(16'h0BAD);
		chk_state(4'h2, 1'b0);
		unlock(pw(3));
		chk_state(4'h2, 1'b1);
		wr(HI, 16'h00F0);
		chk_state(4'h1, 1'b1);
		wr(45'h0, 16'h00A0);
		wr(45'h1, 16'h0BAD);
		enter(16'h0060);
		rd(45'h1, pw(1), "pwd_outside");
		wr(45'h0, 16'h00F0);
	endtask : t_pwd

	task automatic t_ppb;
		enter(16'h00C0);
		chk_state(4'h4, 1'b0);
		rd(SEC5 | 45'h123, 16'h0000, "ppb_clear");
		wr(HI, 16'h00A0);
		wr(SEC5 | 45'h3FE, 16'h0000);
		rd(SEC5, 16'h0001, "ppb_set");
		rd(SEC6, 16'h0000, "ppb_other");
		wr(45'h0, 16'h0060);
		rd(SEC5 | 45'h7, 16'h0003, "status");
		wr(HI, 16'h0080);
		wr(SEC5, 16'h0030);
		rd(SEC5, 16'h0000, "ppb_erased");
		enter(16'h00F0);
		chk_state(4'h1, 1'b0);
	endtask : t_ppb

	task automatic t_cfg;
		logic [15:0] r;
		wr(HI | 45'h555, 16'h00AA);
		wr(HI | 45'h2AA, 16'h0011);
		wr(HI | 45'h555, 16'h0060);
		chk_state(4'h1, 1'b1);
		enter(16'h0040);
		rd(HI | 45'h9, 16'h3C5A, "cfg_word");
		@(posedge clk_i);
		cfg_word_i <= 16'hA5C3;
		rd(HI, 16'hA5C3, "cfg_word2");
		u_host.xfer(3'h2, 45'h0, 16'h00F0, r);
		chk_state(4'h8, 1'b1);
		wr(45'h0, 16'h00F0);
		chk_state(4'h1, 1'b1);
		// Status again once unlocked: lock bit must read clear
		enter(16'h00C0);
		wr(45'h0, 16'h0060);
		rd(SEC6, 16'h0000, "status_open");
	endtask : t_cfg

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	initial begin
		repeat (8) @(posedge clk_i);
		chk("ready_rst", 16'h0001, {15'h0000, cmd_ready_o});
		chk("rvalid_rst", 16'h0000, {15'h0000, rd_valid_o});
		chk("rdata_rst", 16'h0000, rd_data_o);
		chk("set_rst", 16'h0001, {12'h000, active_set_o});
		chk("lock_rst", 16'h0000, {15'h0000, pwd_unlocked_o});
		rst_b_i <= 1'b1;
		t_ppb();
		t_pwd();
		t_cfg();
		chk("hang", 16'h0000, {15'h0000, hang});
		end_sim();
	end

	// Whole run is well under half a millisecond
	initial begin
		#2000000;
		num_errors++;
		end_sim();
	end
endmodule : protection_command_sequencer_test
